// ### verilog/tcc_pkg.sv
// Constants shared by the capture timer and its counter core
package tcc_pkg;
  // Register addresses on the special function register port
  localparam logic [7:0]  TCC_ADDR_CONTROL   = 8'hc8;
  localparam logic [7:0]  TCC_ADDR_RELOAD_LO = 8'hc9;
  localparam logic [7:0]  TCC_ADDR_RELOAD_HI = 8'hca;
  localparam logic [7:0]  TCC_ADDR_COUNT_LO  = 8'hcb;
  localparam logic [7:0]  TCC_ADDR_COUNT_HI  = 8'hcc;
  // Control register bit positions
  localparam int          TCC_BIT_HIGH_OVF   = 7;
  localparam int          TCC_BIT_LOW_OVF    = 6;
  localparam int          TCC_BIT_LOW_IRQ_EN = 5;
  localparam int          TCC_BIT_CAPTURE_EN = 4;
  localparam int          TCC_BIT_SPLIT      = 3;
  localparam int          TCC_BIT_RUN        = 2;
  localparam int          TCC_BIT_CAP_SRC    = 1;
  localparam int          TCC_BIT_EXT_CLK    = 0;
  // Reset values and count limits
  localparam logic [7:0]  TCC_CONTROL_RESET  = 8'h00;
  localparam logic [7:0]  TCC_BYTE_RESET     = 8'h00;
  localparam logic [7:0]  TCC_BYTE_MAX       = 8'hff;
  localparam logic [15:0] TCC_WORD_MAX       = 16'hffff;
  localparam logic [15:0] TCC_WORD_ZERO      = 16'h0000;
  localparam logic [7:0]  TCC_READ_UNMAPPED  = 8'h00;
  // Capture source select encodings
  localparam logic        TCC_SRC_USB_SOF    = 1'b0;
  localparam logic        TCC_SRC_LOW_FREQ   = 1'b1;
endpackage : tcc_pkg

// ### verilog/tcc_core_if.sv
// Interface between the control block and the counter core
`timescale 1ns/1ns
interface tcc_core_if;
  logic        run_control_bit;
  logic        split_mode_bit;
  logic        capture_enable_bit;
  logic        capture_event;
  logic        count_tick;
  logic        write_count_low;
  logic        write_count_high;
  logic        write_reload_low;
  logic        write_reload_high;
  logic [7:0]  write_data;
  logic [15:0] count;
  logic [15:0] reload;
  logic        low_wrap;
  logic        high_wrap;

  modport ctrl (
    output run_control_bit, split_mode_bit, capture_enable_bit, capture_event, count_tick,
    output write_count_low, write_count_high, write_reload_low, write_reload_high,
    output write_data,
    input  count, reload, low_wrap, high_wrap
  );
  modport core (
    input  run_control_bit, split_mode_bit, capture_enable_bit, capture_event, count_tick,
    input  write_count_low, write_count_high, write_reload_low, write_reload_high,
    input  write_data,
    output count, reload, low_wrap, high_wrap
  );
endinterface : tcc_core_if

// ### verilog/tcc_counter.sv
// Counter core: count bytes, reload bytes, wrap and capture logic
`timescale 1ns/1ns
module tcc_counter
  import tcc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  tcc_core_if.core  bus
);

  logic [7:0] count_low;
  logic [7:0] count_high;
  logic [7:0] reload_low;
  logic [7:0] reload_high;
  logic [7:0] next_count_low;
  logic [7:0] next_count_high;
  logic [7:0] next_reload_low;
  logic [7:0] next_reload_high;
  logic       next_low_wrap;
  logic       next_high_wrap;
  logic       low_wrap;
  logic       high_wrap;

  // Byte step that wraps to a chosen value past the top
  function automatic logic [7:0] tcc_step8(input logic [7:0] value, input logic [7:0] wrap_to);
    tcc_step8 = (value == TCC_BYTE_MAX) ? wrap_to : value + 8'h01;
  endfunction : tcc_step8

  // Next count, reload and wrap pulses
  always_comb begin
    next_count_low   = count_low;
    next_count_high  = count_high;
    next_reload_low  = reload_low;
    next_reload_high = reload_high;
    next_low_wrap    = 1'b0;
    next_high_wrap   = 1'b0;
    if (bus.split_mode_bit) begin
      // R10 two 8-bit reloads
      // R09 run gates high only
      if (bus.count_tick) begin
        next_count_low = tcc_step8(count_low, reload_low);
        next_low_wrap  = (count_low == TCC_BYTE_MAX); // R08 any mode
        if (bus.run_control_bit) begin
          next_count_high = tcc_step8(count_high, reload_high);
          next_high_wrap  = (count_high == TCC_BYTE_MAX);
        end
      end
    end else if (bus.run_control_bit && bus.count_tick) begin
      // R09 run gates whole count
      next_low_wrap = (count_low == TCC_BYTE_MAX);
      if ({count_high, count_low} == TCC_WORD_MAX) begin
        next_high_wrap = 1'b1;
        // R04 capture wraps to zero
        // R10 otherwise auto-reload
        if (bus.capture_enable_bit) begin
          {next_count_high, next_count_low} = TCC_WORD_ZERO;
        end else begin
          next_count_high = reload_high;
          next_count_low  = reload_low;
        end
      end else begin
        {next_count_high, next_count_low} = {count_high, count_low} + 16'h0001;
      end
    end
    // Software writes to the count win over counting in that cycle
    if (bus.write_count_low) begin
      next_count_low = bus.write_data;
    end
    if (bus.write_count_high) begin
      next_count_high = bus.write_data;
    end
    if (bus.write_reload_low) begin
      next_reload_low = bus.write_data;
    end
    if (bus.write_reload_high) begin
      next_reload_high = bus.write_data;
    end
    // R05 latch count on capture
    // Capture beats a reload write so no measurement is lost
    if (bus.capture_enable_bit && bus.capture_event) begin
      next_reload_low  = count_low;
      next_reload_high = count_high;
    end
  end

  // Register the core state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_low   <= TCC_BYTE_RESET;
      count_high  <= TCC_BYTE_RESET;
      reload_low  <= TCC_BYTE_RESET;
      reload_high <= TCC_BYTE_RESET;
      low_wrap    <= 1'b0;
      high_wrap   <= 1'b0;
    end else begin
      count_low   <= next_count_low;
      count_high  <= next_count_high;
      reload_low  <= next_reload_low;
      reload_high <= next_reload_high;
      low_wrap    <= next_low_wrap;
      high_wrap   <= next_high_wrap;
    end
  end

  // Results back to the control block
  assign bus.count     = {count_high, count_low};
  assign bus.reload    = {reload_high, reload_low};
  assign bus.low_wrap  = low_wrap;
  assign bus.high_wrap = high_wrap;

endmodule : tcc_counter

// ### verilog/timer_capture_control.sv
// Capture timer top: control register, register port, capture events, flags
//
// Notes on behaviour
// R01 - A set capture enable bit puts the timer in capture mode driven by a special event.
// R02 - The capture source select bit picks start-of-frame (0) or oscillator falling edge (1).
// R03 - In oscillator mode every falling edge of the oscillator level makes one capture.
// R04 - With split mode clear the count runs up as 16 bits and wraps 0xFFFF to 0x0000; the code does so only with capture enable set.
// R05 - Each capture copies the whole 16-bit count into the reload byte pair.
// R06 - Each capture requests the timer interrupt when that interrupt is enabled.
// R07 - Hardware sets the high overflow flag on byte or word overflow; only software clears it.
// R08 - Any low byte wrap sets the low flag; it interrupts only if enabled; software clears it.
// R09 - The run control bit gates counting, and only the high byte in split mode.
// R10 - Split mode set gives two 8-bit auto-reload counters, clear gives one 16-bit one.
`timescale 1ns/1ns
module timer_capture_control
  import tcc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_write,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       count_tick,
  input  wire logic       usb_sof,
  input  wire logic       low_freq_oscillator,
  input  wire logic       timer_irq_enable,
  output logic            timer_irq
);

  tcc_core_if core_bus ();

  logic [7:0] timer_control;
  logic [7:0] next_control;
  logic       lfo_prev;
  logic       lfo_fall;
  logic       capture_hit;
  logic [7:0] next_rdata;
  logic       next_irq;
  logic       control_write;

  // Counter core holds count and reload bytes
  tcc_counter u_counter (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bus      (core_bus)
  );

  // Write strobes decoded from the register port
  assign control_write = sfr_write && (sfr_addr == TCC_ADDR_CONTROL);

  // Control fields and writes toward the core
  assign core_bus.run_control_bit    = timer_control[TCC_BIT_RUN];
  assign core_bus.split_mode_bit     = timer_control[TCC_BIT_SPLIT];
  assign core_bus.capture_enable_bit = timer_control[TCC_BIT_CAPTURE_EN];
  assign core_bus.count_tick         = count_tick;
  assign core_bus.write_data         = sfr_wdata;
  assign core_bus.write_count_low    = sfr_write && (sfr_addr == TCC_ADDR_COUNT_LO);
  assign core_bus.write_count_high   = sfr_write && (sfr_addr == TCC_ADDR_COUNT_HI);
  assign core_bus.write_reload_low   = sfr_write && (sfr_addr == TCC_ADDR_RELOAD_LO);
  assign core_bus.write_reload_high  = sfr_write && (sfr_addr == TCC_ADDR_RELOAD_HI);

  // R03 falling edge of oscillator
  // Oscillator arrives already synchronous, so one stage of history is enough
  assign lfo_fall = lfo_prev && !low_freq_oscillator;

  // R01 capture only when enabled
  // R02 source select picks event
  always_comb begin
    capture_hit = 1'b0;
    if (timer_control[TCC_BIT_CAPTURE_EN]) begin
      if (timer_control[TCC_BIT_CAP_SRC] == TCC_SRC_LOW_FREQ) begin
        capture_hit = lfo_fall;
      end else begin
        capture_hit = usb_sof;
      end
    end
  end
  assign core_bus.capture_event = capture_hit;

  // Oscillator history register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lfo_prev <= 1'b0; // Low start avoids a false edge at release
    end else begin
      lfo_prev <= low_freq_oscillator;
    end
  end

  // Next control value with hardware-set flags
  always_comb begin
    next_control = timer_control;
    if (control_write) begin
      next_control = sfr_wdata;
    end
    // R07 high flag set by hardware
    // R06 capture raises high flag
    // Set after the write so an event in a clearing cycle is kept
    if (core_bus.high_wrap || capture_hit) begin
      next_control[TCC_BIT_HIGH_OVF] = 1'b1;
    end
    // R08 low flag on any wrap
    if (core_bus.low_wrap) begin
      next_control[TCC_BIT_LOW_OVF] = 1'b1;
    end
  end

  // Control register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timer_control <= TCC_CONTROL_RESET;
    end else begin
      timer_control <= next_control;
    end
  end

  // Read data mux, unmapped addresses read as zero
  always_comb begin
    case (sfr_addr)
      TCC_ADDR_CONTROL:   next_rdata = timer_control;
      TCC_ADDR_RELOAD_LO: next_rdata = core_bus.reload[7:0];
      TCC_ADDR_RELOAD_HI: next_rdata = core_bus.reload[15:8];
      TCC_ADDR_COUNT_LO:  next_rdata = core_bus.count[7:0];
      TCC_ADDR_COUNT_HI:  next_rdata = core_bus.count[15:8];
      default:            next_rdata = TCC_READ_UNMAPPED;
    endcase
  end

  // Interrupt request from flags
  always_comb begin
    // R06 gated by interrupt enable
    // R08 low flag needs its enable
    next_irq = timer_irq_enable &&
               (timer_control[TCC_BIT_HIGH_OVF] ||
                (timer_control[TCC_BIT_LOW_OVF] && timer_control[TCC_BIT_LOW_IRQ_EN]));
  end

  // Output registers, so every output comes from a flip-flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sfr_rdata <= TCC_READ_UNMAPPED;
      timer_irq <= 1'b0;
    end else begin
      sfr_rdata <= next_rdata;
      timer_irq <= next_irq;
    end
  end

endmodule : timer_capture_control

// ### dv/tcc_asserts.sv
// Port-level checks for the capture timer
`timescale 1ns/1ns
module tcc_asserts
  import tcc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_write,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       count_tick,
  input wire logic       usb_sof,
  input wire logic       low_freq_oscillator,
  input wire logic       timer_irq_enable,
  input wire logic       timer_irq
);
  logic [7:0] ctl;
  default clocking def_cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of software-owned bits; flag bits are not trusted here
  always_ff @(posedge core_clk) begin
    if (!rst_n) ctl <= 8'h00;
    else if (sfr_write && sfr_addr == TCC_ADDR_CONTROL) ctl <= sfr_wdata;
  end
  a_irq_needs_enable: assert property (timer_irq |-> $past(timer_irq_enable))
    else $error("timer_irq raised while disabled");
  a_ctrl_readback: assert property ((sfr_addr == TCC_ADDR_CONTROL)
    |=> sfr_rdata[5:0] == $past(ctl[5:0])) else $error("control bits read back wrong");
  // Read data lags the count by one edge, so the step seen is governed by last cycle's state
  a_run_off_holds: assert property ((sfr_addr == TCC_ADDR_COUNT_LO
    && $past(sfr_addr) == TCC_ADDR_COUNT_LO && !$past(ctl[TCC_BIT_RUN])
    && !$past(ctl[TCC_BIT_SPLIT]) && !$past(sfr_write))
    |=> $stable(sfr_rdata)) else $error("count moved while stopped");
  a_count_steps: assert property ((sfr_addr == TCC_ADDR_COUNT_LO
    && $past(sfr_addr) == TCC_ADDR_COUNT_LO && $past(ctl[TCC_BIT_RUN])
    && !$past(ctl[TCC_BIT_SPLIT]) && $past(ctl[TCC_BIT_CAPTURE_EN]) && $past(count_tick)
    && !$past(sfr_write)) |=> sfr_rdata == $past(sfr_rdata) + 8'h01)
    else $error("count step wrong");
  a_sof_capture_irq: assert property ((ctl[4] && !ctl[1] && usb_sof)
    ##1 timer_irq_enable |=> timer_irq) else $error("frame capture gave no request");
  a_osc_capture_irq: assert property ((ctl[4] && ctl[1] && $past(low_freq_oscillator)
    && !low_freq_oscillator) ##1 timer_irq_enable |=> timer_irq)
    else $error("oscillator capture gave no request");
  a_high_flag_sticky: assert property ((sfr_addr == TCC_ADDR_CONTROL
    && $past(sfr_addr) == TCC_ADDR_CONTROL && !$past(sfr_write)) |=> !$fell(sfr_rdata[7]))
    else $error("high flag cleared without a write");
  a_low_flag_sticky: assert property ((sfr_addr == TCC_ADDR_CONTROL
    && $past(sfr_addr) == TCC_ADDR_CONTROL && !$past(sfr_write)) |=> !$fell(sfr_rdata[6]))
    else $error("low flag cleared without a write");
endmodule : tcc_asserts
bind timer_capture_control tcc_asserts tcc_asserts_inst (.core_clk(core_clk), .rst_n(rst_n),
  .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .count_tick(count_tick), .usb_sof(usb_sof), .low_freq_oscillator(low_freq_oscillator),
  .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq));

// ### dv/tcc_evt_model.sv
// Capture event sources: frame pulse and oscillator level
`timescale 1ns/1ns
module tcc_evt_model (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic sof_req,
  input  wire logic osc_req,
  output logic      usb_sof,
  output logic      low_freq_oscillator
);
  // Launched from the clock so the timer never sees a half-cycle glitch
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      usb_sof             <= 1'b0;
      low_freq_oscillator <= 1'b0;
    end else begin
      usb_sof             <= sof_req;
      low_freq_oscillator <= osc_req;
    end
  end
endmodule : tcc_evt_model

// ### dv/test_timer_capture_control.sv
// Self-checking bench for the capture timer
`timescale 1ns/1ns
module test_timer_capture_control;
  import tcc_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n    = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_write = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic       sof_req = 1'b0;
  logic       osc_req = 1'b0;
  logic       usb_sof;
  logic       low_freq_oscillator;
  logic       timer_irq_enable = 1'b1;
  logic       count_tick = 1'b1;
  logic       timer_irq;
  int         n_errors = 0;
  int         total_checks = 0;
  timer_capture_control timer_capture_control_inst (.core_clk(core_clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .count_tick(count_tick), .usb_sof(usb_sof), .low_freq_oscillator(low_freq_oscillator),
    .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq));
  tcc_evt_model tcc_evt_model_inst (.core_clk(core_clk), .rst_n(rst_n), .sof_req(sof_req),
    .osc_req(osc_req), .usb_sof(usb_sof), .low_freq_oscillator(low_freq_oscillator));
  initial forever #50 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) {sfr_addr, sfr_wdata, sfr_write} <= {a, d, 1'b1};
    @(posedge core_clk) sfr_write <= 1'b0;
  endtask : wr
  // Address held two edges so the read data has settled on it
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge core_clk) sfr_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 chk(nm, e, sfr_rdata);
  endtask : rd
  task automatic ev_sof;
    @(posedge core_clk) sof_req <= 1'b1;
    @(posedge core_clk) sof_req <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : ev_sof
  task automatic ev_osc;
    @(posedge core_clk) osc_req <= 1'b1;
    repeat (2) @(posedge core_clk);
    osc_req <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : ev_osc
  // Run ten steps, freeze, then a frame capture latches the count
  task automatic test_sof_capture;
    wr(TCC_ADDR_CONTROL, 8'h14);
    sfr_addr <= TCC_ADDR_COUNT_LO;
    repeat (8) @(posedge core_clk);
    wr(TCC_ADDR_CONTROL, 8'h10);
    ev_sof();
    rd(TCC_ADDR_RELOAD_LO, 8'h0a, "reload_low_byte");
    rd(TCC_ADDR_RELOAD_HI, 8'h00, "reload_high_byte");
    rd(TCC_ADDR_CONTROL, 8'h90, "timer_control");
    chk("timer_irq", 8'h01, {7'h00, timer_irq});
  endtask : test_sof_capture
  // Oscillator source ignores frames and captures on a falling edge
  task automatic test_osc_capture;
    wr(TCC_ADDR_CONTROL, 8'h12);
    wr(TCC_ADDR_COUNT_LO, 8'h34);
    wr(TCC_ADDR_COUNT_HI, 8'h12);
    ev_sof();
    rd(TCC_ADDR_RELOAD_LO, 8'h0a, "reload_low_byte");
    ev_osc();
    rd(TCC_ADDR_RELOAD_LO, 8'h34, "reload_low_byte");
    rd(TCC_ADDR_RELOAD_HI, 8'h12, "reload_high_byte");
  endtask : test_osc_capture
  // Word wrap in capture mode, both flags, then software clears them
  task automatic test_wrap_flags;
    @(posedge core_clk) timer_irq_enable <= 1'b0;
    wr(TCC_ADDR_CONTROL, 8'h10);
    wr(TCC_ADDR_COUNT_LO, 8'hfe);
    wr(TCC_ADDR_COUNT_HI, 8'hff);
    wr(TCC_ADDR_CONTROL, 8'h34);
    wr(TCC_ADDR_CONTROL, 8'h30);
    rd(TCC_ADDR_COUNT_LO, 8'h00, "count_low_byte");
    rd(TCC_ADDR_COUNT_HI, 8'h00, "count_high_byte");
    rd(TCC_ADDR_CONTROL, 8'hf0, "timer_control");
    chk("timer_irq", 8'h00, {7'h00, timer_irq});
    wr(TCC_ADDR_CONTROL, 8'h00);
    rd(TCC_ADDR_CONTROL, 8'h00, "timer_control");
  endtask : test_wrap_flags
  // Split mode: low byte reloads on its own, stopped high byte holds, tick gates all
  task automatic test_split_irq;
    @(posedge core_clk) timer_irq_enable <= 1'b1;
    wr(TCC_ADDR_RELOAD_LO, 8'hfe);
    wr(TCC_ADDR_COUNT_LO, 8'hfd);
    wr(TCC_ADDR_COUNT_HI, 8'h55);
    wr(TCC_ADDR_CONTROL, 8'h28);
    // Three ticks: fd, fe, ff, then reload to fe
    repeat (3) @(posedge core_clk);
    count_tick <= 1'b0;
    rd(TCC_ADDR_COUNT_LO, 8'hfe, "count_low_byte");
    rd(TCC_ADDR_COUNT_HI, 8'h55, "count_high_byte");
    rd(TCC_ADDR_CONTROL, 8'h68, "timer_control");
    chk("timer_irq", 8'h01, {7'h00, timer_irq});
  endtask : test_split_irq
  task automatic final_report;
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(TCC_ADDR_CONTROL, 8'h00, "timer_control");
    test_sof_capture();
    test_osc_capture();
    test_wrap_flags();
    test_split_irq();
    final_report();
  end
endmodule : test_timer_capture_control
